//--- core/rx_output_pkg.sv
// Purpose: shared constants for the receive output control block
// Assumes: 32-bit apb, one aligned word per register
// Notes: offsets are byte addresses within the block window
package rx_output_pkg;
  localparam logic [31:0] HDR_CAPTURE_ADDR = 32'hCF000024;
  localparam logic [31:0] OUT_CONTROL_ADDR = 32'hCF000028;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'hCF000030;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'hCF000034;
  localparam logic [31:0] HDR_CAPTURE_RESET = 32'h00000000;
  localparam logic [31:0] OUT_CONTROL_RESET = 32'h00000000;
  localparam int MUTE_RELEASE_BIT = 31;
  localparam int MIDI_PRESENT_BIT = 30;
  localparam int AUTO_MUTE_BIT = 29;
  localparam int LOCKED_BIT = 28;
  localparam int DUAL_WIRE_BIT = 27;
  localparam int LOCK_COUNT_MSB = 15;
  localparam int LOCK_COUNT_LSB = 0;
  localparam int HDR_TAG_MSB = 31;
  localparam int HDR_TAG_LSB = 30;
  localparam int HDR_FMT_MSB = 29;
  localparam int HDR_FMT_LSB = 24;
  localparam int HDR_FDF_MSB = 23;
  localparam int HDR_FDF_LSB = 16;
  localparam int HDR_SYT_MSB = 15;
  localparam int HDR_SYT_LSB = 0;
  localparam logic [1:0] HDR_TAG_EXPECTED = 2'h2;
  localparam int IRQ_LOCK_GAINED = 0;
  localparam int IRQ_LOCK_LOST = 1;
  localparam int IRQ_BAD_TAG = 2;
  localparam int IRQ_WIDTH = 3;
  localparam logic [31:0] WRITABLE_CONTROL_MASK = 32'hE800FFFF;
  typedef enum logic {LS_HUNT, LS_LOCKED} lock_state_e;
endpackage : rx_output_pkg

//--- core/audio_rx_output_lock_control.sv
// Purpose: second header capture, output control and lock detector
// Assumes: all inputs synchronous to pclk; one clock domain
// Notes: zero wait states; read data loads in the setup cycle
//
// What this block does
// - each received second header word is captured read-only.
// - the capture shows tag at 31:30, format 29:24, fdf 23:16, syt 15:0.
// - while control bit 31 is zero every emitted data word is muted.
// - when control bit 30 is set the last word of each data block is midi.
// - with control bit 29 set, data is muted while the detector is unlocked.
// - read-only bit 28 shows the lock state machine is locked.
// - control bit 27 selects dual-wire operation.
// - lock comes only after the programmed count of clean periods.
// - a slip drops lock at once and restarts the count.
`timescale 1ns/1ps
module audio_rx_output_lock_control
  import rx_output_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int COUNT_W = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hdr_valid,
  input wire logic [31:0] hdr_word,
  input wire logic bus_tick,
  input wire logic sample_slip,
  input wire logic in_valid,
  input wire logic [DATA_W-1:0] in_data,
  input wire logic in_block_last,
  output logic out_valid,
  output logic [DATA_W-1:0] out_data,
  output logic out_is_midi,
  output logic out_block_last,
  output logic dual_wire,
  output logic locked,
  output logic irq
);
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [31:0] hdr_r;
  logic [31:0] ctrl_r;
  logic [IRQ_WIDTH-1:0] status_r;
  logic [IRQ_WIDTH-1:0] status_nxt;
  logic [IRQ_WIDTH-1:0] mask_r;
  lock_state_e state_r;
  lock_state_e state_nxt;
  logic [COUNT_W-1:0] count_r;
  logic [COUNT_W-1:0] count_nxt;
  logic [IRQ_WIDTH-1:0] events;
  logic [31:0] ctrl_view;
  logic [31:0] hdr_view;
  logic [31:0] rdata_sel;

  wire access = psel && penable;
  wire setup_rd = psel && !penable && !pwrite;
  wire wr = access && pwrite;
  wire sel_hdr = (paddr == HDR_CAPTURE_ADDR);
  wire sel_ctrl = (paddr == OUT_CONTROL_ADDR);
  wire sel_stat = (paddr == IRQ_STATUS_ADDR);
  wire sel_mask = (paddr == IRQ_MASK_ADDR);
  wire mapped = sel_hdr || sel_ctrl || sel_stat || sel_mask;
  wire wr_ctrl = wr && sel_ctrl;
  wire wr_stat = wr && sel_stat;
  wire wr_mask = wr && sel_mask;

  function automatic logic [31:0] strobe_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : strobe_merge

  wire [31:0] ctrl_wr_val =
    strobe_merge(ctrl_r, pwdata, pstrb) & WRITABLE_CONTROL_MASK;
  // status clear honours the byte strobes like any write
  wire [31:0] stat_clr = strobe_merge(32'h00000000, pwdata, pstrb);
  wire [31:0] mask_wr_val = strobe_merge({29'h0, mask_r}, pwdata, pstrb);
  wire [IRQ_WIDTH-1:0] clr_bits = wr_stat ? stat_clr[IRQ_WIDTH-1:0] : '0;

  // ----------------------------------------------------------------
  // named fields
  // ----------------------------------------------------------------
  wire ctl_mute_release = ctrl_r[MUTE_RELEASE_BIT];
  wire ctl_midi_present = ctrl_r[MIDI_PRESENT_BIT];
  wire ctl_auto_mute = ctrl_r[AUTO_MUTE_BIT];
  wire ctl_dual_wire = ctrl_r[DUAL_WIRE_BIT];
  wire [COUNT_W-1:0] lock_target = ctrl_r[LOCK_COUNT_MSB:LOCK_COUNT_LSB];
  wire [HDR_TAG_MSB-HDR_TAG_LSB:0] rx_tag =
    hdr_word[HDR_TAG_MSB:HDR_TAG_LSB];
  wire tag_bad = (rx_tag != HDR_TAG_EXPECTED);

  // the capture is shown as tag, format, fdf and syt fields
  wire [HDR_TAG_MSB-HDR_TAG_LSB:0] cap_tag = hdr_r[HDR_TAG_MSB:HDR_TAG_LSB];
  wire [HDR_FMT_MSB-HDR_FMT_LSB:0] cap_fmt = hdr_r[HDR_FMT_MSB:HDR_FMT_LSB];
  wire [HDR_FDF_MSB-HDR_FDF_LSB:0] cap_fdf = hdr_r[HDR_FDF_MSB:HDR_FDF_LSB];
  wire [HDR_SYT_MSB-HDR_SYT_LSB:0] cap_syt = hdr_r[HDR_SYT_MSB:HDR_SYT_LSB];
  assign hdr_view = {cap_tag, cap_fmt, cap_fdf, cap_syt};

  // ----------------------------------------------------------------
  // register readback
  // ----------------------------------------------------------------
  // locked bit merged on read; writes to it are dropped by the mask
  always_comb
  begin
    ctrl_view = ctrl_r;
    ctrl_view[LOCKED_BIT] = locked;
  end

  assign rdata_sel = sel_hdr ? hdr_view :
                     sel_ctrl ? ctrl_view :
                     sel_stat ? {29'h0, status_r} :
                     sel_mask ? {29'h0, mask_r} : 32'h00000000;

  // no wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // read data loads in the setup cycle so that it already stands at
  // the access edge, where the master takes it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup_rd)
      prdata <= rdata_sel;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hdr_r <= HDR_CAPTURE_RESET;
    else if (hdr_valid)
      hdr_r <= hdr_word;
  end

  // bit 28 and the reserved bits are masked off before the write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= OUT_CONTROL_RESET;
    else if (wr_ctrl)
      ctrl_r <= ctrl_wr_val;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_r <= '0;
    else if (wr_mask)
      mask_r <= mask_wr_val[IRQ_WIDTH-1:0];
  end

  assign status_nxt = (status_r & ~clr_bits) | events;

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_r <= '0;
    else
      status_r <= status_nxt;
  end

  // ----------------------------------------------------------------
  // lock detector
  // ----------------------------------------------------------------
  // a count of zero locks at once; the counter stops at the target
  // a tick in a slip cycle is not counted, so the count restarts clean
  wire count_done = (count_r >= lock_target);

  always_comb
  begin
    state_nxt = state_r;
    count_nxt = count_r;
    case (state_r)
      LS_HUNT:
      begin
        if (sample_slip)
        begin
          count_nxt = '0;
        end
        else if (count_done)
        begin
          state_nxt = LS_LOCKED;
        end
        else if (bus_tick)
        begin
          count_nxt = count_r + 1'b1;
        end
      end
      LS_LOCKED:
      begin
        if (sample_slip)
        begin
          state_nxt = LS_HUNT;
          count_nxt = '0;
        end
      end
      default:
      begin
        state_nxt = LS_HUNT;
        count_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= LS_HUNT;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_r <= '0;
    else
      count_r <= count_nxt;
  end

  assign locked = (state_r == LS_LOCKED);

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  // events are one-cycle pulses from the lock machine and header path
  wire entering_lock = (state_r == LS_HUNT) && (state_nxt == LS_LOCKED);
  wire leaving_lock = (state_r == LS_LOCKED) && (state_nxt == LS_HUNT);
  assign events[IRQ_LOCK_GAINED] = entering_lock;
  assign events[IRQ_LOCK_LOST] = leaving_lock;
  assign events[IRQ_BAD_TAG] = hdr_valid && tag_bad;
  // level output: a masked event stays pending in status
  assign irq = |(status_r & mask_r);

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  // midi words are muted too: a mute silences the whole stream
  wire mute = !ctl_mute_release ||
              (ctl_auto_mute && !locked);
  wire midi_word = ctl_midi_present && in_block_last;
  wire [DATA_W-1:0] data_nxt = mute ? '0 : in_data;

  // data and flags share one cycle of latency
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_valid <= 1'b0;
    else
      out_valid <= in_valid;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_data <= '0;
    else
      out_data <= data_nxt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_is_midi <= 1'b0;
    else
      out_is_midi <= in_valid && midi_word;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_block_last <= 1'b0;
    else
      out_block_last <= in_valid && in_block_last;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dual_wire <= 1'b0;
    else
      dual_wire <= ctl_dual_wire;
  end
endmodule : audio_rx_output_lock_control

//--- tb/link_model.sv
// Purpose: link side source of headers, ticks, slips and words
// Assumes: pulse is called just after a rising pclk edge
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ps
module link_model (
  input logic pclk,
  output logic hdr_valid,
  output logic [31:0] hdr_word,
  output logic bus_tick,
  output logic sample_slip,
  output logic in_valid,
  output logic [31:0] in_data,
  output logic in_block_last
);
  initial {hdr_valid, hdr_word, bus_tick, sample_slip} = 0;
  initial {in_valid, in_data, in_block_last} = 0;
  // k: 0 header, 1 tick, 2 slip, 3 word
  task pulse(input int k, input logic [31:0] d, input logic l);
    {hdr_valid, bus_tick, sample_slip, in_valid} <= 4'h8 >> k;
    {hdr_word, in_data, in_block_last} <= {d, d, l};
    @(posedge pclk);
    {hdr_valid, bus_tick, sample_slip, in_valid} <= 4'h0;
    {hdr_word, in_data} <= {~d, ~d};
  endtask : pulse
endmodule : link_model

//--- tb/audio_rx_output_lock_control_monitor.sv
// Purpose: port checks of the output control block
// Assumes: writes use all byte strobes
// Notes: mirrors control, header and tick count from the ports
`timescale 1ns/1ps
module audio_rx_output_lock_control_monitor
  import rx_output_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic hdr_valid,
  input logic [31:0] hdr_word,
  input logic bus_tick,
  input logic sample_slip,
  input logic in_valid,
  input logic [31:0] in_data,
  input logic in_block_last,
  input logic [31:0] out_data,
  input logic out_is_midi,
  input logic dual_wire,
  input logic locked
);
  logic [31:0] ctl_r, hdr_r;
  logic [15:0] tk_r;
  // read data loads in the setup cycle of a read
  wire rd = psel && !penable && !pwrite;
  wire mute = in_valid && (!ctl_r[31] || ctl_r[29] && !locked);
  wire hunt_done = !locked && tk_r >= ctl_r[15:0] && !sample_slip;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {ctl_r, hdr_r, tk_r} <= '0;
    else
    begin
      if (psel && penable && pwrite && paddr == OUT_CONTROL_ADDR)
        ctl_r <= pwdata & WRITABLE_CONTROL_MASK;
      if (hdr_valid)
        hdr_r <= hdr_word;
      tk_r <= sample_slip ? '0 : tk_r + 16'(bus_tick && !locked);
    end
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_mute_zero:
    assert property (mute |=> out_data == 0)
    else $error("muted word not zero");
  chk_pass_data:
    assert property (in_valid && !mute |=> out_data == $past(in_data))
    else $error("word changed");
  chk_midi_flag:
    assert property (in_valid && in_block_last |=>
      out_is_midi == $past(ctl_r[30]))
    else $error("midi flag");
  chk_dual_copy:
    assert property ($changed(ctl_r[27]) |=> dual_wire == ctl_r[27])
    else $error("dual wire");
  chk_lock_early:
    assert property ($rose(locked) |-> $past(tk_r) >= $past(ctl_r[15:0]))
    else $error("lock too early");
  chk_lock_due: assert property (hunt_done |=> locked)
    else $error("lock missing");
  chk_slip_drop: assert property (sample_slip |=> !locked)
    else $error("lock kept after slip");
  chk_hdr_read:
    assert property (rd && paddr == HDR_CAPTURE_ADDR |=>
      prdata == $past(hdr_r))
    else $error("header read");
  chk_lock_bit:
    assert property (rd && paddr == OUT_CONTROL_ADDR |=>
      prdata[28] == $past(locked))
    else $error("lock bit read");
  cover property ($rose(locked));
  cover property (sample_slip ##1 !locked);
  cover property (in_valid && in_block_last && ctl_r[30]);
endmodule : audio_rx_output_lock_control_monitor
bind audio_rx_output_lock_control audio_rx_output_lock_control_monitor mon (.*);

//--- tb/tb.sv
// Purpose: self-checking bench of the output control block
// Assumes: link_model feeds the stream side
// Notes: read data is taken at the access edge
`timescale 1ns/1ps
module tb;
  import rx_output_pkg::*;
  typedef struct {logic [31:0] c, d, o; logic l, m;} row_s;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ev;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rv, hdr_word, in_data, out_data;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, hdr_valid, bus_tick, sample_slip, in_valid;
  logic in_block_last, out_valid, out_is_midi, out_block_last;
  logic dual_wire, locked, irq;
  int errors = 0, total_checks = 0;
  // muted midi word still flags midi but carries zero
  row_s rows[4] = '{'{32'h40000000, 32'hA5A50001, 32'h0, 1, 1},
    '{32'h80000000, 32'h12345678, 32'h12345678, 0, 0},
    '{32'hC0000000, 32'h0BADCAFE, 32'h0BADCAFE, 1, 1},
    '{32'hA8000000, 32'h00C0FFEE, 32'h00C0FFEE, 1, 0}};
  link_model lnk (.*);
  audio_rx_output_lock_control dut (.*);
  initial forever #5 pclk = ~pclk;
  task conclude;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task bus(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n == 50)
    begin
      errors++;
      conclude();
    end
    ev = pslverr;
    rv = prdata;
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask : bus
  initial
  begin
    repeat (2) @(posedge pclk);
    chk(locked, 0);
    presetn <= 1;
    @(posedge pclk);
    bus(1, IRQ_MASK_ADDR, 32'h1);
    chk(irq, 1);
    bus(1, IRQ_STATUS_ADDR, 32'h1);
    chk(irq, 0);
    lnk.pulse(0, 32'h9A123456, 0);
    bus(1, HDR_CAPTURE_ADDR, 32'h0);
    bus(0, HDR_CAPTURE_ADDR, 0);
    chk(rv, 32'h9A123456);
    bus(0, 32'hCF00002C, 0);
    chk(ev, 1);
    lnk.pulse(0, 32'h5A000000, 0);
    bus(0, IRQ_STATUS_ADDR, 0);
    chk(rv, 32'h4);
    bus(1, IRQ_STATUS_ADDR, 32'h4);
    foreach (rows[i])
    begin
      bus(1, OUT_CONTROL_ADDR, rows[i].c);
      lnk.pulse(3, rows[i].d, rows[i].l);
      #1;
      chk(out_data, rows[i].o);
      chk(out_is_midi, rows[i].m);
      chk(out_valid, 1);
      chk(out_block_last, rows[i].l);
      @(posedge pclk);
    end
    chk(dual_wire, 1);
    bus(1, OUT_CONTROL_ADDR, 32'hB0000003);
    lnk.pulse(2, 0, 0);
    bus(0, OUT_CONTROL_ADDR, 0);
    chk(rv, 32'hA0000003);
    chk(irq, 0);
    repeat (2)
    begin
      lnk.pulse(1, 0, 0);
      @(posedge pclk);
    end
    lnk.pulse(3, 32'h00001111, 0);
    #1;
    chk(out_data, 0);
    chk(locked, 0);
    @(posedge pclk);
    lnk.pulse(1, 0, 0);
    @(posedge pclk);
    #1;
    chk(locked, 1);
    chk(irq, 1);
    @(posedge pclk);
    presetn <= 0;
    @(posedge pclk);
    #1;
    chk(locked, 0);
    chk(irq, 0);
    @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    #1;
    chk(locked, 1);
    conclude();
  end
endmodule : tb
